// [rtl/rvc_regs.sv]
// Summary of operation
// - the first mismatch byte address reads as a low word and a 25-bit high word.
// - a 57-bit count of tested bytes reads as a low word and a 25-bit high word.
// - the expected 512-bit line at the first mismatch reads as sixteen words, low first.
// - the read 512-bit line at the first mismatch reads as sixteen words, low first.
// - writes into the status region change nothing.
// - sixteen write-only submission dwords per channel drive each controller core.
// - four completion dwords per channel read back from each controller core.
// - the version register returns the controller core version word.
// - a read-only 8 KB identify window per channel, controller then namespace data.
// - a read-write 8 KB custom command RAM window per channel from 0x18000.
// - the verify-fail status bit sets on a mismatch and clears only when a new read command starts.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rvc_map.svh"

module rvc_regs (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // avalon-mm slave
    input wire rvc_pkg::rvc_addr_t avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire rvc_pkg::rvc_word_t avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output rvc_pkg::rvc_word_t avs_readdata_out,
    output logic avs_waitrequest_out,
    // pattern generator side
    input wire logic read_cmd_start_in,
    input wire logic data_beat_in,
    input wire logic mismatch_in,
    input wire rvc_pkg::rvc_bytes_t mismatch_addr_in,
    input wire rvc_pkg::rvc_line_t expected_line_in,
    input wire rvc_pkg::rvc_line_t observed_line_in,
    output logic verify_fail_out,
    // controller core side
    input wire rvc_pkg::rvc_line_t custom_completion_dwords_in,
    input wire logic [3:0] completion_valid_in,
    input wire rvc_pkg::rvc_word_t core_version_word_in,
    output logic [2047:0] custom_submission_dwords_out,
    // identify ram and custom command ram port
    output rvc_pkg::rvc_ramaddr_t ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output rvc_pkg::rvc_word_t ram_wdata_out,
    input wire rvc_pkg::rvc_word_t ram_rdata_in,
    // interrupt
    output logic irq_out
);
    import rvc_pkg::*;

    // ==========================================
    // address decode helpers
    // window test, both bounds inclusive
    function automatic logic in_win(
        input rvc_addr_t a,
        input rvc_addr_t lo,
        input rvc_addr_t hi
    );
        return (a >= lo) && (a <= hi);
    endfunction : in_win

    // bit offset of word k inside a line: address bits 5:2 times 32
    function automatic logic [8:0] line_pos(input rvc_addr_t a);
        return {a[5:2], `RVC_WORD_SHIFT};
    endfunction : line_pos

    // ==========================================
    // state declarations
    // bus handshake and answer
    rvc_state_e state, next_state;
    logic wait_q, next_wait_q;
    rvc_word_t rdata, next_rdata;
    // first mismatch capture and verify flag
    rvc_bytes_t fail_addr, next_fail_addr;
    rvc_line_t exp_line, next_exp_line;
    rvc_line_t obs_line, next_obs_line;
    logic captured, next_captured;
    logic vfail, next_vfail;
    // tested byte counter
    rvc_bytes_t byte_cnt, next_byte_cnt;
    // write-only submission entries, sixteen per channel
    rvc_word_t subm [0:`RVC_SUBM_WORDS-1];
    rvc_word_t next_subm [0:`RVC_SUBM_WORDS-1];
    // interrupt status, mask and registered line
    rvc_irq_t irq_sts, next_irq_sts;
    rvc_irq_t irq_mask, next_irq_mask;
    logic irq_q, next_irq_q;
    // registered ram port towards identify and custom storage
    rvc_ramaddr_t ram_addr, next_ram_addr;
    logic ram_rd, next_ram_rd;
    logic ram_wr, next_ram_wr;
    rvc_word_t ram_wdata, next_ram_wdata;
    // decode of the request on the bus
    logic req;
    logic acc_wr;
    logic ram_win;
    logic new_fail;
    rvc_word_t reg_rd;

    // request decode; a write takes effect at the ack edge only
    // writes to read-only or unmapped addresses are answered and dropped
    assign req = avs_read_in || avs_write_in;
    assign acc_wr = (state == ST_ACK) && avs_write_in;
    assign ram_win = in_win(avs_address_in, `RVC_OFS_IDEN_LO, `RVC_OFS_CRAM_HI);
    assign new_fail = mismatch_in && (!captured || read_cmd_start_in);

    // ==========================================
    // register read mux
    always_comb begin
        reg_rd = `RVC_ZERO_WORD;
        // unmapped and write-only addresses read as zero
        // 57-bit values read low word first, the high word padded with zeros
        // line windows return word k of the 512-bit line at base plus 4k
        // completion dwords and the version word pass straight through
        // interrupt registers sit above the core version word
        if (avs_address_in == `RVC_OFS_FAIL_LO) begin
            reg_rd = fail_addr[31:0];
        end else if (avs_address_in == `RVC_OFS_FAIL_HI) begin
            reg_rd = {`RVC_HI_PAD, fail_addr[56:32]};
        end else if (avs_address_in == `RVC_OFS_CNT_LO) begin
            reg_rd = byte_cnt[31:0];
        end else if (avs_address_in == `RVC_OFS_CNT_HI) begin
            reg_rd = {`RVC_HI_PAD, byte_cnt[56:32]};
        end else if (in_win(avs_address_in, `RVC_OFS_EXP_LO, `RVC_OFS_EXP_HI)) begin
            reg_rd = exp_line[line_pos(avs_address_in) +: 32];
        end else if (in_win(avs_address_in, `RVC_OFS_OBS_LO, `RVC_OFS_OBS_HI)) begin
            reg_rd = obs_line[line_pos(avs_address_in) +: 32];
        end else if (in_win(avs_address_in, `RVC_OFS_COMP_LO, `RVC_OFS_COMP_HI)) begin
            reg_rd = custom_completion_dwords_in[line_pos(avs_address_in) +: 32];
        end else if (avs_address_in == `RVC_OFS_VERSION) begin
            reg_rd = core_version_word_in;
        end else if (avs_address_in == `RVC_OFS_IRQ_STS) begin
            reg_rd = {`RVC_IRQ_PAD, irq_sts};
        end else if (avs_address_in == `RVC_OFS_IRQ_MASK) begin
            reg_rd = {`RVC_IRQ_PAD, irq_mask};
        end
    end

    // ==========================================
    // bus handshake state machine
    always_comb begin
        next_state = state;
        next_rdata = rdata;
        case (state)
            ST_IDLE: begin
                // window reads take the slow path through the ram port
                // register accesses answer in the next cycle
                if (avs_read_in && ram_win) begin
                    next_state = ST_RAM;
                end else if (req) begin
                    next_state = ST_ACK;
                    next_rdata = avs_read_in ? reg_rd : `RVC_ZERO_WORD;
                end
            end
            ST_RAM: begin
                next_state = ST_DATA; // read strobe is out this cycle
            end
            ST_DATA: begin
                // ram data arrives one cycle after the strobe
                next_state = ST_ACK;
                next_rdata = ram_rdata_in;
            end
            ST_ACK: begin
                // waitrequest is low in this one cycle only
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // waitrequest stays high in every state but the answer
        next_wait_q = (next_state != ST_ACK);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            wait_q <= 1'b1;
            rdata <= `RVC_ZERO_WORD;
        end else begin
            state <= next_state;
            wait_q <= next_wait_q;
            rdata <= next_rdata;
        end
    end

    // ==========================================
    // first mismatch capture and verify flag
    always_comb begin
        next_fail_addr = fail_addr;
        next_exp_line = exp_line;
        next_obs_line = obs_line;
        next_captured = captured;
        next_vfail = vfail;
        // a new read command rearms capture and clears the flag
        if (read_cmd_start_in) begin
            next_captured = 1'b0;
            next_vfail = 1'b0;
        end
        // only the first mismatch is kept; a mismatch with the start wins
        // later mismatches of the same command cannot overwrite the capture
        if (new_fail) begin
            next_fail_addr = mismatch_addr_in;
            next_exp_line = expected_line_in;
            next_obs_line = observed_line_in;
            next_captured = 1'b1;
            next_vfail = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fail_addr <= `RVC_ZERO_BYTES;
            exp_line <= `RVC_ZERO_LINE;
            obs_line <= `RVC_ZERO_LINE;
            captured <= 1'b0;
            vfail <= 1'b0;
        end else begin
            fail_addr <= next_fail_addr;
            exp_line <= next_exp_line;
            obs_line <= next_obs_line;
            captured <= next_captured;
            vfail <= next_vfail;
        end
    end

    // ==========================================
    // tested byte counter, one 64-byte line per beat
    // a start together with a beat counts that beat for the new command
    // the count wraps only after 2^57 bytes, far beyond any test
    always_comb begin
        next_byte_cnt = byte_cnt;
        if (read_cmd_start_in) begin
            next_byte_cnt = `RVC_ZERO_BYTES;
        end
        if (data_beat_in) begin
            next_byte_cnt = next_byte_cnt + `RVC_BEAT_BYTES;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            byte_cnt <= `RVC_ZERO_BYTES;
        end else begin
            byte_cnt <= next_byte_cnt;
        end
    end

    // ==========================================
    // custom submission entries, byte lane writes
    always_comb begin
        for (int w = 0; w < `RVC_SUBM_WORDS; w++) begin
            next_subm[w] = subm[w];
        end
        // status region writes match no window here and are dropped
        // the read mux has no write path, so no status register can change
        if (acc_wr && in_win(avs_address_in, `RVC_OFS_SUBM_LO, `RVC_OFS_SUBM_HI)) begin
            for (int b = 0; b < `RVC_BYTE_LANES; b++) begin
                if (avs_byteenable_in[b]) begin
                    next_subm[avs_address_in[7:2]][b*8 +: 8] =
                        avs_writedata_in[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int w = 0; w < `RVC_SUBM_WORDS; w++) begin
                subm[w] <= `RVC_ZERO_WORD;
            end
        end else begin
            for (int w = 0; w < `RVC_SUBM_WORDS; w++) begin
                subm[w] <= next_subm[w];
            end
        end
    end

    // flatten entries: channel n holds words 16n..16n+15
    genvar gi;
    generate
        for (gi = 0; gi < `RVC_SUBM_WORDS; gi++) begin : g_subm
            assign custom_submission_dwords_out[gi*32 +: 32] = subm[gi];
        end
    endgenerate

    // ==========================================
    // interrupt status, mask and output
    // bit 0 marks the first capture, bits 4:1 the completion pulses of channels 0 to 3
    // the line is registered from the next values so it tracks status without lag
    always_comb begin
        rvc_irq_t set_bits;
        rvc_irq_t clr_bits;
        set_bits = `RVC_ZERO_IRQ;
        clr_bits = `RVC_ZERO_IRQ;
        next_irq_mask = irq_mask;
        set_bits[`RVC_IRQ_FAIL] = new_fail;
        set_bits[`RVC_IRQ_COMP_LSB +: 4] = completion_valid_in;
        if (acc_wr && (avs_address_in == `RVC_OFS_IRQ_STS) && avs_byteenable_in[0]) begin
            clr_bits = avs_writedata_in[4:0];
        end
        if (acc_wr && (avs_address_in == `RVC_OFS_IRQ_MASK) && avs_byteenable_in[0]) begin
            next_irq_mask = avs_writedata_in[4:0];
        end
        // a new event wins over a clear in the same cycle
        next_irq_sts = (irq_sts & ~clr_bits) | set_bits;
        next_irq_q = |(next_irq_sts & next_irq_mask);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_sts <= `RVC_ZERO_IRQ;
            irq_mask <= `RVC_ZERO_IRQ;
            irq_q <= 1'b0;
        end else begin
            irq_sts <= next_irq_sts;
            irq_mask <= next_irq_mask;
            irq_q <= next_irq_q;
        end
    end

    // ==========================================
    // identify and custom ram port
    // reads leave only from idle and writes only from the answer state, so they never overlap
    always_comb begin
        next_ram_addr = ram_addr;
        next_ram_wdata = ram_wdata;
        next_ram_rd = 1'b0;
        next_ram_wr = 1'b0;
        // read strobe one cycle, data back in the next
        if ((state == ST_IDLE) && avs_read_in && ram_win) begin
            next_ram_addr = avs_address_in[16:2];
            next_ram_rd = 1'b1;
        end
        // identify window is read only, only the custom ram takes writes
        if (acc_wr && in_win(avs_address_in, `RVC_OFS_CRAM_LO, `RVC_OFS_CRAM_HI)) begin
            next_ram_addr = avs_address_in[16:2];
            next_ram_wdata = avs_writedata_in;
            next_ram_wr = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ram_addr <= `RVC_ZERO_RAMADDR;
            ram_wdata <= `RVC_ZERO_WORD;
            ram_rd <= 1'b0;
            ram_wr <= 1'b0;
        end else begin
            ram_addr <= next_ram_addr;
            ram_wdata <= next_ram_wdata;
            ram_rd <= next_ram_rd;
            ram_wr <= next_ram_wr;
        end
    end

    // ==========================================
    // outputs straight from flip-flops
    // no logic sits between these registers and the pins
    assign avs_readdata_out = rdata;
    assign avs_waitrequest_out = wait_q;
    assign verify_fail_out = vfail;
    assign irq_out = irq_q;
    assign ram_addr_out = ram_addr;
    assign ram_rd_out = ram_rd;
    assign ram_wr_out = ram_wr;
    assign ram_wdata_out = ram_wdata;

endmodule : rvc_regs

`default_nettype wire

// [rtl/rvc_map.svh]
`ifndef RVC_MAP_SVH
`define RVC_MAP_SVH
// ==========================================
// register offsets (byte addresses)
`define RVC_OFS_FAIL_LO 17'h00200
`define RVC_OFS_FAIL_HI 17'h00204
`define RVC_OFS_CNT_LO 17'h00208
`define RVC_OFS_CNT_HI 17'h0020c
`define RVC_OFS_EXP_LO 17'h00280
`define RVC_OFS_EXP_HI 17'h002bc
`define RVC_OFS_OBS_LO 17'h002c0
`define RVC_OFS_OBS_HI 17'h002fc
`define RVC_OFS_STS_LO 17'h00100
`define RVC_OFS_STS_HI 17'h002ff
`define RVC_OFS_SUBM_LO 17'h00400
`define RVC_OFS_SUBM_HI 17'h004ff
`define RVC_OFS_COMP_LO 17'h00500
`define RVC_OFS_COMP_HI 17'h0053f
`define RVC_OFS_VERSION 17'h00800
`define RVC_OFS_IRQ_STS 17'h00900
`define RVC_OFS_IRQ_MASK 17'h00904
`define RVC_OFS_IDEN_LO 17'h10000
`define RVC_OFS_IDEN_HI 17'h17fff
`define RVC_OFS_CRAM_LO 17'h18000
`define RVC_OFS_CRAM_HI 17'h1ffff
// ==========================================
// field positions and widths
`define RVC_HI_BITS 25
`define RVC_HI_PAD 7'h00
`define RVC_WORD_SHIFT 5'h00
`define RVC_SUBM_WORDS 64
`define RVC_BYTE_LANES 4
`define RVC_IRQ_BITS 5
`define RVC_IRQ_FAIL 0
`define RVC_IRQ_COMP_LSB 1
// ==========================================
// reset values and step sizes
`define RVC_ZERO_WORD 32'h0000_0000
`define RVC_ZERO_BYTES 57'h0
`define RVC_ZERO_LINE 512'h0
`define RVC_ZERO_IRQ 5'h00
`define RVC_IRQ_PAD 27'h0000000
`define RVC_ZERO_RAMADDR 15'h0000
`define RVC_BEAT_BYTES 57'h40
`endif

// [rtl/rvc_pkg.sv]
// ==========================================
// shared types of the verify register bank
package rvc_pkg;
    typedef logic [31:0] rvc_word_t;
    typedef logic [16:0] rvc_addr_t;
    typedef logic [511:0] rvc_line_t;
    typedef logic [56:0] rvc_bytes_t;
    typedef logic [14:0] rvc_ramaddr_t;
    typedef logic [4:0] rvc_irq_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RAM,
        ST_DATA,
        ST_ACK
    } rvc_state_e;
endpackage : rvc_pkg

// [sim/rvc_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bus timing and capture checks of the verify register bank
module rvc_regs_checker (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire rvc_pkg::rvc_addr_t avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic read_cmd_start_in,
    input wire logic mismatch_in,
    input wire logic verify_fail_out,
    input wire rvc_pkg::rvc_ramaddr_t ram_addr_out,
    input wire logic ram_rd_out,
    input wire logic ram_wr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // register reads answer one cycle after the request
    property p_reg_read;
        $rose(avs_read_in) && avs_address_in < 17'h10000 |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("register read answer late");
    // every write answers one cycle after the request
    property p_write;
        $rose(avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_write: assert property (p_write) else $error("write answer late");
    // window reads go through the ram port and answer in cycle 3
    property p_ram_read;
        $rose(avs_read_in) && avs_address_in >= 17'h10000 |-> ##1 ram_rd_out && ram_addr_out == avs_address_in[16:2] ##1 avs_waitrequest_out [*1] ##1 !avs_waitrequest_out;
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("window read sequence wrong");
    // the answer lasts one cycle only
    property p_ack_single;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("answer longer than one cycle");
    // a mismatch raises the fail flag next cycle
    property p_fail_set;
        mismatch_in |=> verify_fail_out;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag not set");
    // a new read command alone clears the fail flag
    property p_fail_clear;
        read_cmd_start_in && !mismatch_in |=> !verify_fail_out;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("fail flag not cleared");
    // without start or mismatch the flag holds
    property p_fail_hold;
        !mismatch_in && !read_cmd_start_in |=> $stable(verify_fail_out);
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("fail flag moved");
    // ram writes only follow an answered write into the command ram
    property p_ram_write;
        ram_wr_out |-> $past(avs_write_in) && !$past(avs_waitrequest_out) && $past(avs_address_in) >= 17'h18000;
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("stray ram write");
    c_ram_read: cover property (ram_rd_out);
    c_fail: cover property (mismatch_in ##1 verify_fail_out);
    c_ram_write: cover property (ram_wr_out);
endmodule : rvc_regs_checker
bind rvc_regs rvc_regs_checker u_rvc_regs_checker (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
    .read_cmd_start_in(read_cmd_start_in), .mismatch_in(mismatch_in),
    .verify_fail_out(verify_fail_out), .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out),
    .ram_wr_out(ram_wr_out));
`default_nettype wire

// [sim/rvc_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module rvc_regs_tb;
    import rvc_pkg::*;
    logic clk_sys_in = 0, reset_n_in = 0, avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out;
    logic read_cmd_start_in = 0, data_beat_in = 0, mismatch_in = 0, verify_fail_out, irq_out;
    logic ram_rd_out, ram_wr_out;
    logic [3:0] avs_byteenable_in = 4'hf, completion_valid_in = 4'h0;
    logic [2047:0] custom_submission_dwords_out;
    rvc_addr_t avs_address_in = 0;
    rvc_word_t avs_writedata_in = 0, avs_readdata_out, core_version_word_in = 0, ram_wdata_out;
    rvc_word_t ram_rdata_in = 0, q, v, wr_d, seed = 32'h26;
    rvc_bytes_t mismatch_addr_in = 0, ma, cnt;
    rvc_line_t expected_line_in = 0, observed_line_in = 0, custom_completion_dwords_in = 0, el, ol;
    rvc_ramaddr_t ram_addr_out, wr_a;
    int errors = 0, n_compared = 0, cyc = 0, wr_seen = 0, k, w0;
    rvc_regs u_rvc_regs (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .read_cmd_start_in(read_cmd_start_in), .data_beat_in(data_beat_in),
        .mismatch_in(mismatch_in), .mismatch_addr_in(mismatch_addr_in),
        .expected_line_in(expected_line_in), .observed_line_in(observed_line_in),
        .verify_fail_out(verify_fail_out), .custom_completion_dwords_in(custom_completion_dwords_in),
        .completion_valid_in(completion_valid_in), .core_version_word_in(core_version_word_in),
        .custom_submission_dwords_out(custom_submission_dwords_out), .ram_addr_out(ram_addr_out),
        .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out), .ram_wdata_out(ram_wdata_out),
        .ram_rdata_in(ram_rdata_in), .irq_out(irq_out));
    // ==========================================
    // clock, timeout, ram stand-in
    always #25 clk_sys_in = ~clk_sys_in;
    // cut a hang short
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // answer ram reads one cycle later and log ram writes
    always @(posedge clk_sys_in) begin
        if (ram_rd_out) ram_rdata_in <= ram_fn(ram_addr_out);
        if (ram_wr_out) begin
            wr_seen++;
            wr_a = ram_addr_out;
            wr_d = ram_wdata_out;
        end
    end
    // ==========================================
    // helpers
    function automatic rvc_word_t ram_fn(input rvc_ramaddr_t a);
        return {a, 17'h0} ^ 32'h3c3c_a5a5;
    endfunction : ram_fn
    function rvc_word_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input rvc_addr_t a, input rvc_word_t d);
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= d;
        // hold the request until a rising edge sees waitrequest low
        @(posedge clk_sys_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clk_sys_in);
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        // one more edge so a write has landed before the caller looks
        @(posedge clk_sys_in);
    endtask : bus
    task automatic rdc(input int a, input rvc_word_t e, input string nm);
        bus(0, rvc_addr_t'(a), 0);
        `CHK(nm, e, q)
    endtask : rdc
    // one generator cycle: start, beat, mismatch
    task automatic gen(input logic s, input logic b, input logic m);
        @(posedge clk_sys_in);
        read_cmd_start_in <= s;
        data_beat_in <= b;
        mismatch_in <= m;
        @(posedge clk_sys_in);
        {read_cmd_start_in, data_beat_in, mismatch_in} <= 3'h0;
    endtask : gen
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys_in);
        reset_n_in <= 1;
        v = rnd();
        core_version_word_in <= v;
        for (int i = 0; i < 16; i++) custom_completion_dwords_in[32*i+:32] <= rnd();
        rdc(32'h800, v, "version");
        for (int i = 0; i < 16; i++) rdc(32'h500 + i * 4, custom_completion_dwords_in[32*i+:32], "completion");
        $display("version and completion test done");
        for (int i = 0; i < 10; i++) begin
            k = (i == 0) ? 0 : (i == 1) ? 63 : int'(rnd() % 64);
            v = rnd();
            bus(1, rvc_addr_t'(32'h400 + k * 4), v);
            `CHK("submission", v, custom_submission_dwords_out[k*32+:32])
            rdc(32'h400 + k * 4, 32'h0, "submission read");
        end
        $display("submission test done");
        k = int'(rnd() % 8) + 2;
        cnt = 57'(k * 64 + 64);
        ma = 57'({rnd(), rnd()});
        for (int i = 0; i < 16; i++) begin
            el[32*i+:32] = rnd();
            ol[32*i+:32] = rnd();
        end
        gen(1, 1, 0);
        repeat (k) gen(0, 1, 0);
        mismatch_addr_in <= ma;
        expected_line_in <= el;
        observed_line_in <= ol;
        gen(0, 0, 1);
        mismatch_addr_in <= ~ma;
        expected_line_in <= ~el;
        observed_line_in <= ~ol;
        gen(0, 0, 1);
        `CHK("fail flag", 1'b1, verify_fail_out)
        for (int r = 0; r < 2; r++) begin
            rdc(32'h200, ma[31:0], "fail addr lo");
            rdc(32'h204, {7'h00, ma[56:32]}, "fail addr hi");
            rdc(32'h208, cnt[31:0], "count lo");
            rdc(32'h20c, {7'h00, cnt[56:32]}, "count hi");
            for (int i = 0; i < 16; i++) rdc(32'h280 + i * 4, el[32*i+:32], "expected");
            for (int i = 0; i < 16; i++) rdc(32'h2c0 + i * 4, ol[32*i+:32], "observed");
            for (int i = 0; i < 4; i++) bus(1, rvc_addr_t'(32'h200 + (rnd() & 32'hfc)), rnd());
        end
        $display("capture and read-only test done");
        rdc(32'h900, 32'h1, "irq status");
        bus(1, 17'h00904, 32'h1f);
        repeat (2) @(negedge clk_sys_in);
        `CHK("irq on", 1'b1, irq_out)
        bus(1, 17'h00900, 32'h1);
        repeat (2) @(negedge clk_sys_in);
        `CHK("irq cleared", 1'b0, irq_out)
        @(posedge clk_sys_in);
        completion_valid_in <= 4'h4;
        @(posedge clk_sys_in);
        completion_valid_in <= 4'h0;
        rdc(32'h900, 32'h8, "irq completion");
        bus(1, 17'h00904, 32'h0);
        repeat (2) @(negedge clk_sys_in);
        `CHK("irq masked", 1'b0, irq_out)
        gen(1, 0, 0);
        @(negedge clk_sys_in);
        `CHK("fail cleared", 1'b0, verify_fail_out)
        rdc(32'h208, 32'h0, "count cleared");
        gen(0, 0, 1);
        rdc(32'h200, ~ma[31:0], "new capture");
        $display("status and interrupt test done");
        for (int i = 0; i < 8; i++) begin
            v = rvc_word_t'(32'h10000 + (rnd() & 32'hfffc));
            rdc(v, ram_fn(v[16:2]), "window read");
            w0 = wr_seen;
            v = rvc_word_t'(32'h18000 + (rnd() & 32'h7ffc));
            bus(1, v[16:0], ~v);
            repeat (2) @(negedge clk_sys_in);
            `CHK("ram write addr", v[16:2], wr_a)
            `CHK("ram write data", ~v, wr_d)
            bus(1, rvc_addr_t'(32'h10000 + (rnd() & 32'h7ffc)), v);
            repeat (2) @(negedge clk_sys_in);
            `CHK("ram write count", w0 + 1, wr_seen)
        end
        $display("ram window test done");
        give_verdict();
    end
endmodule : rvc_regs_tb
`default_nettype wire
